// [rtl/tws_top.sv]
// Two-wire serial assist: open-drain clock/data lines, sampling, condition detection, clock stretching
`timescale 1ns/1ns
module tws_top
  import tws_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic PORT_B_BIT4_PAD_IN,
  output logic PORT_B_BIT4_PAD_OUT,
  output logic PORT_B_BIT4_PAD_OE_OUT,
  input wire logic PORT_B_BIT5_PAD_IN,
  output logic PORT_B_BIT5_PAD_OUT,
  output logic PORT_B_BIT5_PAD_OE_OUT,
  input wire logic [1:0] PORT_B_DRIVE_IN,
  input wire logic [1:0] PORT_B_OE_IN,
  output logic FALLING_CONDITION_IRQ_OUT,
  output logic RISING_CONDITION_IRQ_OUT,
  output logic IRQ_OUT
);
  import tws_pkg::*;

  // ==========================================
  // Pad synchronisation and edge finding
  logic clock_line_value;
  logic data_line_value;
  logic clk_rise;
  logic clk_fall;
  logic dat_rise;
  logic dat_fall;

  tws_sync u_sync_clk
  (
    .clk_in(SYS_CLK_IN),
    .arst_n_in(ARST_N_IN),
    .async_in(PORT_B_BIT4_PAD_IN),
    .sync_out(clock_line_value)
  );
  tws_sync u_sync_dat
  (
    .clk_in(SYS_CLK_IN),
    .arst_n_in(ARST_N_IN),
    .async_in(PORT_B_BIT5_PAD_IN),
    .sync_out(data_line_value)
  );
  tws_edge u_edge_clk
  (
    .clk_in(SYS_CLK_IN),
    .arst_n_in(ARST_N_IN),
    .level_in(clock_line_value),
    .rise_out(clk_rise),
    .fall_out(clk_fall)
  );
  tws_edge u_edge_dat
  (
    .clk_in(SYS_CLK_IN),
    .arst_n_in(ARST_N_IN),
    .level_in(data_line_value),
    .rise_out(dat_rise),
    .fall_out(dat_fall)
  );

  // ==========================================
  // Bus decode
  logic setup;
  logic wr;
  logic rd;
  logic mapped;

  assign setup = PSEL_IN & ~PENABLE_IN;
  // Registers answer in the setup cycle, so every access phase ends at its first edge
  assign wr = PSEL_IN & PENABLE_IN & PWRITE_IN & PSTRB_IN[0];
  assign rd = PSEL_IN & PENABLE_IN & ~PWRITE_IN;

  always_comb
  begin
    unique case (PADDR_IN)
      TWS_ADDR_DATA_LINE, TWS_ADDR_CLOCK_LINE, TWS_ADDR_CTRL, TWS_ADDR_FALL_FLAG,
      TWS_ADDR_RISE_FLAG, TWS_ADDR_SAMPLE, TWS_ADDR_NEW_SAMPLE, TWS_ADDR_IRQ_STATUS,
      TWS_ADDR_IRQ_MASK: mapped = 1'h1;
      default: mapped = 1'h0;
    endcase
  end

  // ==========================================
  // Software registers
  logic data_drive_q;
  logic clock_drive_q;
  logic block_enable_q;
  logic uncond_en_q;
  logic cond_en_q;
  logic [1:0] irq_mask_q;

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      data_drive_q <= TWS_LINE_DRIVE_RST;
      clock_drive_q <= TWS_LINE_DRIVE_RST;
      {cond_en_q, uncond_en_q, block_enable_q} <= TWS_CTRL_RST;
      irq_mask_q <= TWS_IRQ_MASK_RST;
    end
    else if (wr)
    begin
      if (PADDR_IN == TWS_ADDR_DATA_LINE)
        data_drive_q <= PWDATA_IN[0];
      if (PADDR_IN == TWS_ADDR_CLOCK_LINE)
        clock_drive_q <= PWDATA_IN[0];
      if (PADDR_IN == TWS_ADDR_CTRL)
      begin
        block_enable_q <= PWDATA_IN[TWS_CTRL_ENABLE_BIT];
        uncond_en_q <= PWDATA_IN[TWS_CTRL_UNCOND_BIT];
        cond_en_q <= PWDATA_IN[TWS_CTRL_COND_BIT];
      end
      if (PADDR_IN == TWS_ADDR_IRQ_MASK)
        irq_mask_q <= PWDATA_IN[TWS_IRQ_WIDTH-1:0];
    end
  end

  // ==========================================
  // Condition detection
  logic fall_cond;
  logic rise_cond;
  logic falling_condition_detected_q;
  logic rising_condition_detected_q;

  // Clock level taken from the same synchronised sample as the data edge
  assign fall_cond = block_enable_q & dat_fall & clock_line_value;
  assign rise_cond = block_enable_q & dat_rise & clock_line_value;

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      falling_condition_detected_q <= 1'h0;
    else if (fall_cond)
      falling_condition_detected_q <= 1'h1;
    else if (wr && PADDR_IN == TWS_ADDR_FALL_FLAG)
      falling_condition_detected_q <= 1'h0;
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      rising_condition_detected_q <= 1'h0;
    else if (rise_cond)
      rising_condition_detected_q <= 1'h1;
    else if (wr && PADDR_IN == TWS_ADDR_RISE_FLAG)
      rising_condition_detected_q <= 1'h0;
  end

  // ==========================================
  // Clock stretching
  logic stretch_active_flag_q;
  logic release_wr;
  logic stretch_start;

  assign release_wr = wr && PADDR_IN == TWS_ADDR_SAMPLE;
  assign stretch_start = block_enable_q & clk_fall &
    (uncond_en_q | (cond_en_q & falling_condition_detected_q));

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      stretch_active_flag_q <= 1'h0;
    else if (stretch_start)
      stretch_active_flag_q <= 1'h1;
    else if (release_wr || !block_enable_q)
      stretch_active_flag_q <= 1'h0;
  end

  // ==========================================
  // Data sampling
  logic sampled_data_value_q;
  logic new_sample_pending_q;

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      sampled_data_value_q <= 1'h0;
    else if (block_enable_q && clk_rise)
      sampled_data_value_q <= data_line_value;
  end

  // A capture on the setup edge of a sample read misses the read data, so it must stay pending
  logic late_capture_q;

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      late_capture_q <= 1'h0;
    else
      late_capture_q <= setup && !PWRITE_IN && PADDR_IN == TWS_ADDR_SAMPLE && block_enable_q && clk_rise;
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      new_sample_pending_q <= 1'h0;
    else if (block_enable_q && clk_rise)
      new_sample_pending_q <= 1'h1;
    else if (rd && PADDR_IN == TWS_ADDR_SAMPLE && !late_capture_q)
      new_sample_pending_q <= 1'h0;
  end

  // ==========================================
  // Interrupts: sticky status cleared by reading it, event wins over the clear
  logic [1:0] irq_status_q;
  logic [1:0] irq_event;

  always_comb
  begin
    irq_event = 2'h0;
    irq_event[TWS_IRQ_FALL_BIT] = fall_cond;
    irq_event[TWS_IRQ_RISE_BIT] = rise_cond;
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
      irq_status_q <= 2'h0;
    else if (rd && PADDR_IN == TWS_ADDR_IRQ_STATUS)
      // Clear only what the read reported: an event caught at the setup edge stays pending
      irq_status_q <= (irq_status_q & ~PRDATA_OUT[TWS_IRQ_WIDTH-1:0]) | irq_event;
    else
      irq_status_q <= irq_status_q | irq_event;
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      FALLING_CONDITION_IRQ_OUT <= 1'h0;
      RISING_CONDITION_IRQ_OUT <= 1'h0;
      IRQ_OUT <= 1'h0;
    end
    else
    begin
      FALLING_CONDITION_IRQ_OUT <= fall_cond;
      RISING_CONDITION_IRQ_OUT <= rise_cond;
      IRQ_OUT <= |((irq_status_q | irq_event) & irq_mask_q);
    end
  end

  // ==========================================
  // Pad drive
  logic clk_low;
  logic dat_low;

  // Open drain: only ever drive a zero, release otherwise
  assign clk_low = ~clock_drive_q | stretch_active_flag_q | stretch_start;
  assign dat_low = ~data_drive_q;

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      PORT_B_BIT4_PAD_OUT <= 1'h0;
      PORT_B_BIT4_PAD_OE_OUT <= 1'h0;
      PORT_B_BIT5_PAD_OUT <= 1'h0;
      PORT_B_BIT5_PAD_OE_OUT <= 1'h0;
    end
    else if (block_enable_q)
    begin
      PORT_B_BIT4_PAD_OUT <= 1'h0;
      PORT_B_BIT4_PAD_OE_OUT <= clk_low;
      PORT_B_BIT5_PAD_OUT <= 1'h0;
      PORT_B_BIT5_PAD_OE_OUT <= dat_low;
    end
    else
    begin
      // Disabled: the port's own settings own the pads again
      PORT_B_BIT4_PAD_OUT <= PORT_B_DRIVE_IN[0];
      PORT_B_BIT4_PAD_OE_OUT <= PORT_B_OE_IN[0];
      PORT_B_BIT5_PAD_OUT <= PORT_B_DRIVE_IN[1];
      PORT_B_BIT5_PAD_OE_OUT <= PORT_B_OE_IN[1];
    end
  end

  // ==========================================
  // Read data, registered in the setup cycle
  logic [31:0] rdata_d;

  always_comb
  begin
    rdata_d = 32'h0;
    unique case (PADDR_IN)
      TWS_ADDR_DATA_LINE: rdata_d[0] = data_line_value;
      TWS_ADDR_CLOCK_LINE: rdata_d[0] = clock_line_value;
      TWS_ADDR_CTRL:
      begin
        rdata_d[TWS_CTRL_ENABLE_BIT] = block_enable_q;
        rdata_d[TWS_CTRL_UNCOND_BIT] = uncond_en_q;
        rdata_d[TWS_CTRL_COND_BIT] = cond_en_q;
        rdata_d[TWS_CTRL_STRETCH_BIT] = stretch_active_flag_q;
      end
      TWS_ADDR_FALL_FLAG: rdata_d[0] = falling_condition_detected_q;
      TWS_ADDR_RISE_FLAG: rdata_d[0] = rising_condition_detected_q;
      TWS_ADDR_SAMPLE: rdata_d[0] = sampled_data_value_q;
      TWS_ADDR_NEW_SAMPLE: rdata_d[0] = new_sample_pending_q;
      TWS_ADDR_IRQ_STATUS: rdata_d[1:0] = irq_status_q;
      TWS_ADDR_IRQ_MASK: rdata_d[1:0] = irq_mask_q;
      default: rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      PRDATA_OUT <= 32'h0;
      PREADY_OUT <= 1'h0;
      PSLVERR_OUT <= 1'h0;
    end
    else
    begin
      PREADY_OUT <= setup;
      PSLVERR_OUT <= setup & ~mapped;
      if (setup)
        PRDATA_OUT <= rdata_d;
    end
  end
endmodule

// [rtl/tws_pkg.sv]
// Package: register map, field positions and reset values of the two-wire serial assist block
package tws_pkg;
  // ==========================================
  // Register byte addresses
  localparam logic [7:0] TWS_ADDR_DATA_LINE = 8'h00;
  localparam logic [7:0] TWS_ADDR_CLOCK_LINE = 8'h04;
  localparam logic [7:0] TWS_ADDR_CTRL = 8'h08;
  localparam logic [7:0] TWS_ADDR_FALL_FLAG = 8'h0c;
  localparam logic [7:0] TWS_ADDR_RISE_FLAG = 8'h10;
  localparam logic [7:0] TWS_ADDR_SAMPLE = 8'h14;
  localparam logic [7:0] TWS_ADDR_NEW_SAMPLE = 8'h18;
  localparam logic [7:0] TWS_ADDR_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] TWS_ADDR_IRQ_MASK = 8'h20;
  // ==========================================
  // Control register fields
  localparam int TWS_CTRL_ENABLE_BIT = 0;
  localparam int TWS_CTRL_UNCOND_BIT = 1;
  localparam int TWS_CTRL_COND_BIT = 2;
  localparam int TWS_CTRL_STRETCH_BIT = 3;
  // Interrupt status fields
  localparam int TWS_IRQ_FALL_BIT = 0;
  localparam int TWS_IRQ_RISE_BIT = 1;
  localparam int TWS_IRQ_WIDTH = 2;
  // ==========================================
  // Reset values
  localparam logic TWS_LINE_DRIVE_RST = 1'h1;
  localparam logic [2:0] TWS_CTRL_RST = 3'h0;
  localparam logic [1:0] TWS_IRQ_MASK_RST = 2'h0;
endpackage

// [rtl/tws_sync.sv]
// Two-flop synchroniser for one pad level
`timescale 1ns/1ns
module tws_sync
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta_q <= 1'h1;
      sync_out <= 1'h1;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// [rtl/tws_edge.sv]
// Edge finder on a synchronised level
`timescale 1ns/1ns
module tws_edge
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic level_in,
  output logic rise_out,
  output logic fall_out
);
  logic prev_q;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      prev_q <= 1'h1;
    else
      prev_q <= level_in;
  end

  assign rise_out = level_in & ~prev_q;
  assign fall_out = ~level_in & prev_q;
endmodule

// [tb/tws_sva.sv]
// Checker of pad, interrupt and bus timing of the two-wire assist
`timescale 1ns/1ns
module tws_sva
  import tws_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic PORT_B_BIT4_PAD_IN,
  input wire logic PORT_B_BIT4_PAD_OUT,
  input wire logic PORT_B_BIT4_PAD_OE_OUT,
  input wire logic PORT_B_BIT5_PAD_IN,
  input wire logic PORT_B_BIT5_PAD_OUT,
  input wire logic PORT_B_BIT5_PAD_OE_OUT,
  input wire logic FALLING_CONDITION_IRQ_OUT,
  input wire logic RISING_CONDITION_IRQ_OUT,
  input wire logic IRQ_OUT
);
  logic [2:0] ctl_q;
  logic [1:0] msk_q;
  logic [1:0] c_q;
  logic [1:0] d_q;
  logic dd_q;
  logic cd_q;
  wire wr = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN & PSTRB_IN[0];
  // ==========================================
  // Shadow of the writable fields
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
    if (!ARST_N_IN)
    begin
      ctl_q <= 3'h0;
      msk_q <= 2'h0;
      dd_q <= 1'b1;
      cd_q <= 1'b1;
    end
    else if (wr)
    begin
      if (PADDR_IN == TWS_ADDR_CTRL) ctl_q <= PWDATA_IN[2:0];
      if (PADDR_IN == TWS_ADDR_IRQ_MASK) msk_q <= PWDATA_IN[1:0];
      if (PADDR_IN == TWS_ADDR_DATA_LINE) dd_q <= PWDATA_IN[0];
      if (PADDR_IN == TWS_ADDR_CLOCK_LINE) cd_q <= PWDATA_IN[0];
    end
  // Same two-flop depth as the design, so edges line up
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
    if (!ARST_N_IN)
    begin
      c_q <= 2'h3;
      d_q <= 2'h3;
    end
    else
    begin
      c_q <= {c_q[0], PORT_B_BIT4_PAD_IN};
      d_q <= {d_q[0], PORT_B_BIT5_PAD_IN};
    end
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  wire on = ctl_q[0];
  // ==========================================
  // Properties
  property p_fall_pulse; FALLING_CONDITION_IRQ_OUT |=> !FALLING_CONDITION_IRQ_OUT; endproperty
  a_fall_pulse: assert property (p_fall_pulse) else $error("fall irq longer than a cycle");
  property p_rise_pulse; RISING_CONDITION_IRQ_OUT |=> !RISING_CONDITION_IRQ_OUT; endproperty
  a_rise_pulse: assert property (p_rise_pulse) else $error("rise irq longer than a cycle");
  property p_fall_seen; on && $past(on) && c_q[1] && $fell(d_q[1]) |-> ##[1:4] FALLING_CONDITION_IRQ_OUT; endproperty
  a_fall_seen: assert property (p_fall_seen) else $error("falling condition missed");
  property p_rise_seen; on && $past(on) && c_q[1] && $rose(d_q[1]) |-> ##[1:4] RISING_CONDITION_IRQ_OUT; endproperty
  a_rise_seen: assert property (p_rise_seen) else $error("rising condition missed");
  property p_no_wait; PSEL_IN && !PENABLE_IN |=> PREADY_OUT; endproperty
  a_no_wait: assert property (p_no_wait) else $error("no ready in access cycle");
  property p_err_ready; PSLVERR_OUT |-> PREADY_OUT; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_open_drain;
    on && $past(on) |-> !(PORT_B_BIT4_PAD_OE_OUT && PORT_B_BIT4_PAD_OUT) && !(PORT_B_BIT5_PAD_OE_OUT && PORT_B_BIT5_PAD_OUT);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pad driven high");
  property p_data_drive; on && $past(on) && dd_q == $past(dd_q) |-> PORT_B_BIT5_PAD_OE_OUT == !dd_q; endproperty
  a_data_drive: assert property (p_data_drive) else $error("data pad not following drive");
  property p_uncond; ctl_q[1:0] == 2'h3 && $fell(c_q[1]) |-> ##[1:3] PORT_B_BIT4_PAD_OE_OUT; endproperty
  a_uncond: assert property (p_uncond) else $error("clock not stretched");
  property p_release; wr && PADDR_IN == TWS_ADDR_SAMPLE && cd_q |-> ##[1:2] !PORT_B_BIT4_PAD_OE_OUT; endproperty
  a_release: assert property (p_release) else $error("clock not released");
  property p_mask; msk_q == 2'h0 && $past(msk_q) == 2'h0 |-> !IRQ_OUT; endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt raised");
  c_fall: cover property (FALLING_CONDITION_IRQ_OUT);
  c_rise: cover property (RISING_CONDITION_IRQ_OUT);
  c_stretch: cover property (on && cd_q && PORT_B_BIT4_PAD_OE_OUT);
endmodule

// [tb/tws_line_model.sv]
// Far-side two-wire device: open-drain clock and data with pull-ups
`timescale 1ns/1ns
module tws_line_model
(
  input wire logic clk_oe_in,
  input wire logic clk_drv_in,
  input wire logic dat_oe_in,
  input wire logic dat_drv_in,
  output logic clk_line_out,
  output logic dat_line_out
);
  logic clk_rel = 1'b1;
  logic dat_rel = 1'b1;
  // Pull-ups: a released line reads high, any low driver wins
  assign clk_line_out = clk_rel & ~(clk_oe_in & ~clk_drv_in);
  assign dat_line_out = dat_rel & ~(dat_oe_in & ~dat_drv_in);
  // Data moves only while the clock is low; one bit per 160 ns
  // Line changes land on system clock edges, so they are scheduled non-blocking to stay race free
  task automatic send_bit(input logic b);
    dat_rel <= b;
    #40 clk_rel <= 1'b1;
    wait (clk_line_out === 1'b1);
    #80 clk_rel <= 1'b0;
    #40;
  endtask
  task automatic start_cond();
    dat_rel <= 1'b1;
    #40 clk_rel <= 1'b1;
    #40 dat_rel <= 1'b0;
    #40 clk_rel <= 1'b0;
    #40;
  endtask
  task automatic stop_cond();
    dat_rel <= 1'b0;
    #40 clk_rel <= 1'b1;
    #40 dat_rel <= 1'b1;
    #40;
  endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench of the two-wire serial assist
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
  import tws_pkg::*;
  logic clk;
  logic arst_n;
  logic psel;
  logic pen;
  logic pwr;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic c_line;
  logic c_out;
  logic c_oe;
  logic d_line;
  logic d_out;
  logic d_oe;
  logic [1:0] drv;
  logic [1:0] oe;
  logic fi;
  logic ri;
  logic irq;
  logic b;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int fall_n = 0;
  int rise_n = 0;
  logic [32:0] exp_q[$];
  logic [32:0] exp_v;
  tws_top dut_u (.SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .PORT_B_BIT4_PAD_IN(c_line), .PORT_B_BIT4_PAD_OUT(c_out), .PORT_B_BIT4_PAD_OE_OUT(c_oe),
    .PORT_B_BIT5_PAD_IN(d_line), .PORT_B_BIT5_PAD_OUT(d_out), .PORT_B_BIT5_PAD_OE_OUT(d_oe), .PORT_B_DRIVE_IN(drv),
    .PORT_B_OE_IN(oe), .FALLING_CONDITION_IRQ_OUT(fi), .RISING_CONDITION_IRQ_OUT(ri), .IRQ_OUT(irq));
  tws_line_model line_u (.clk_oe_in(c_oe), .clk_drv_in(c_out), .dat_oe_in(d_oe), .dat_drv_in(d_out),
    .clk_line_out(c_line), .dat_line_out(d_line));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic final_report();
    $display("Checked %0d, bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================
  // Read results and interrupt pulses
  always @(posedge clk)
  begin
    cyc++;
    // Pop once: the compare macro names its expected value twice
    if (psel && pen && pready === 1'b1 && !pwr)
    begin
      exp_v = exp_q.pop_front();
      `CHK({pslverr, prdata}, exp_v)
    end
    if (fi === 1'b1) fall_n++;
    if (ri === 1'b1) rise_n++;
    if (cyc == 30000)
    begin
      bad_count++;
      final_report();
    end
  end
  // ==========================================
  // APB master
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  // Pads take a few cycles through the synchroniser before a read sees them
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    repeat (4) @(posedge clk);
    exp_q.push_back({err, e});
    xfer(1'b0, a, 32'h0);
  endtask
  initial
  begin
    arst_n = 1'b0;
    {psel, pen, pwr, paddr, pwdata} = '0;
    pstrb = 4'hf;
    drv = 2'h3;
    oe = 2'h0;
    void'($urandom(32'he54332b9));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rd(8'(i * 4), {31'h0, i < 2}, i == 9);
    oe <= 2'h3;
    repeat (3) @(posedge clk);
    `CHK({c_oe, c_out, d_oe, d_out}, 4'hf)
    wr(TWS_ADDR_IRQ_MASK, 32'h3);
    wr(TWS_ADDR_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    `CHK({c_oe, d_oe}, 2'h0)
    wr(TWS_ADDR_CLOCK_LINE, 32'h0);
    rd(TWS_ADDR_CLOCK_LINE, 32'h0);
    line_u.clk_rel <= 1'b0;
    wr(TWS_ADDR_CLOCK_LINE, 32'h1);
    rd(TWS_ADDR_CLOCK_LINE, 32'h0);
    wr(TWS_ADDR_DATA_LINE, 32'h0);
    rd(TWS_ADDR_DATA_LINE, 32'h0);
    wr(TWS_ADDR_DATA_LINE, 32'h1);
    rd(TWS_ADDR_DATA_LINE, 32'h1);
    line_u.clk_rel <= 1'b1;
    line_u.start_cond();
    `CHK(irq, 1'b1)
    rd(TWS_ADDR_FALL_FLAG, 32'h1);
    rd(TWS_ADDR_IRQ_STATUS, 32'h1);
    rd(TWS_ADDR_RISE_FLAG, 32'h0);
    wr(TWS_ADDR_FALL_FLAG, $urandom());
    rd(TWS_ADDR_FALL_FLAG, 32'h0);
    `CHK(irq, 1'b0)
    for (int i = 0; i < 4; i++)
    begin
      b = 1'($urandom());
      line_u.send_bit(b);
      rd(TWS_ADDR_NEW_SAMPLE, 32'h1);
      rd(TWS_ADDR_SAMPLE, {31'h0, b});
      rd(TWS_ADDR_NEW_SAMPLE, 32'h0);
    end
    line_u.stop_cond();
    rd(TWS_ADDR_RISE_FLAG, 32'h1);
    rd(TWS_ADDR_IRQ_STATUS, 32'h2);
    wr(TWS_ADDR_RISE_FLAG, 32'h0);
    rd(TWS_ADDR_RISE_FLAG, 32'h0);
    wr(TWS_ADDR_CTRL, 32'h3);
    line_u.send_bit(1'b1);
    rd(TWS_ADDR_CTRL, 32'hb);
    rd(TWS_ADDR_CLOCK_LINE, 32'h0);
    wr(TWS_ADDR_SAMPLE, $urandom());
    rd(TWS_ADDR_CTRL, 32'h3);
    `CHK(c_oe, 1'b0)
    // A write without the low byte strobe must leave the mask alone
    pstrb <= 4'he;
    wr(TWS_ADDR_IRQ_MASK, 32'h0);
    pstrb <= 4'hf;
    rd(TWS_ADDR_IRQ_MASK, 32'h3);
    wr(TWS_ADDR_IRQ_MASK, 32'h0);
    wr(TWS_ADDR_CTRL, 32'h5);
    line_u.send_bit(1'b1);
    repeat (4) @(posedge clk);
    `CHK(c_oe, 1'b0)
    line_u.start_cond();
    `CHK(irq, 1'b0)
    rd(TWS_ADDR_CTRL, 32'hd);
    wr(TWS_ADDR_SAMPLE, 32'h0);
    rd(TWS_ADDR_CTRL, 32'h5);
    `CHK(fall_n, 2)
    `CHK(rise_n, 1)
    final_report();
  end
endmodule
bind tws_top tws_sva sva_u (.SYS_CLK_IN, .ARST_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN,
  .PSTRB_IN, .PREADY_OUT, .PSLVERR_OUT, .PORT_B_BIT4_PAD_IN, .PORT_B_BIT4_PAD_OUT, .PORT_B_BIT4_PAD_OE_OUT,
  .PORT_B_BIT5_PAD_IN, .PORT_B_BIT5_PAD_OUT, .PORT_B_BIT5_PAD_OE_OUT, .FALLING_CONDITION_IRQ_OUT,
  .RISING_CONDITION_IRQ_OUT, .IRQ_OUT);
